// ### dha_consts.svh
// Purpose: Shared constants of the debug handshake acknowledge block.
// Assumes: One bus clock at the rate given below.
// Notes: Counts are in bus clock cycles unless a name says otherwise.
`ifndef DHA_CONSTS_SVH
`define DHA_CONSTS_SVH

// Bus clock rate in MHz.
`define DHA_CLK_MHZ 100
// Width of the acknowledge pulse counter.
`define DHA_ACK_CNT_W 5
// Length of the low acknowledge pulse on the pin, in bus clock cycles.
`define DHA_ACK_PULSE_CYC 5'h10
// Reset value of the handshake enable flag.
`define DHA_ACK_EN_RST 1'h0
// Idle counter value of the pulse generator.
`define DHA_CNT_ZERO 5'h00
// Value that the pin output carries whenever it is enabled.
`define DHA_PIN_LOW 1'h0

`endif

// ### dha_pkg.sv
// Purpose: Types of the debug handshake acknowledge block.
// Assumes: The command decoder of the debug halt interface runs on the same clock.
// Notes: Command codes are the decoder's internal encoding.
`include "dha_consts.svh"

package dha_pkg;

  // Decoded command classes seen by the handshake logic.
  typedef enum logic [3:0] {
    DHA_CMD_NONE        = 4'b0000,
    DHA_CMD_ACK_ENABLE  = 4'b0001,
    DHA_CMD_ACK_DISABLE = 4'b0010,
    DHA_CMD_READ        = 4'b0011,
    DHA_CMD_WRITE       = 4'b0100,
    DHA_CMD_HALT_REQ    = 4'b0101,
    DHA_CMD_RESUME      = 4'b0110,
    DHA_CMD_RESUME_UNTIL = 4'b0111,
    DHA_CMD_SINGLE_STEP = 4'b1000,
    DHA_CMD_RESUME_TAG  = 4'b1001,
    DHA_CMD_TIMING_PROBE = 4'b1010
  } dha_cmd_t;

  // Handshake sequencer states.
  typedef enum logic [2:0] {
    DHA_S_IDLE       = 3'b000,
    DHA_S_WAIT_BUS   = 3'b001,
    DHA_S_WAIT_ENTER = 3'b010,
    DHA_S_WAIT_EXIT  = 3'b011,
    DHA_S_SEND       = 3'b100,
    DHA_S_PULSE      = 3'b101
  } dha_state_t;

  // One decoded command from the serial decoder.
  typedef struct packed {
    logic valid;
    dha_cmd_t code;
  } dha_cmd_req_t;

  // Progress of the internal bus access belonging to a command.
  typedef struct packed {
    logic bus_done;
    logic wr_data_done;
  } dha_bus_stat_t;

endpackage

// ### dha_sync2.sv
// Purpose: Two flip-flop synchroniser for one level from the pin.
// Assumes: The input may change at any time relative to ref_clk.
// Notes: The first stage is read only by the second stage.
`timescale 1ns/1ps

module dha_sync2 (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Level in and synchronised level out.
  input wire logic async_in,
  output logic sync_out
);

  logic meta;

  // The line idles high, so both stages reset high.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      meta <= 1'h1;
      sync_out <= 1'h1;
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end

endmodule

// ### dha_pulse_gen.sv
// Purpose: Drives one low acknowledge pulse of fixed length on the open-drain pin.
// Assumes: start is a one-cycle pulse from logic on ref_clk.
// Notes: A start while a pulse runs is ignored; the line is only ever pulled low.
`timescale 1ns/1ps
`include "dha_consts.svh"

module dha_pulse_gen (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Pulse request and status.
  input wire logic start,
  output logic busy,
  // Open-drain pin drive.
  output logic pin_out,
  output logic pin_oe_n
);

  logic [`DHA_ACK_CNT_W-1:0] cnt;
  logic [`DHA_ACK_CNT_W-1:0] next_cnt;

  // Count the pulse down; the pin is enabled exactly while the count runs.
  always_comb begin
    next_cnt = cnt;
    if (cnt != `DHA_CNT_ZERO) begin
      next_cnt = cnt - 5'h01;
    end else if (start) begin
      next_cnt = `DHA_ACK_PULSE_CYC;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cnt <= `DHA_CNT_ZERO;
      pin_oe_n <= 1'h1;
    end else begin
      cnt <= next_cnt;
      pin_oe_n <= (next_cnt == `DHA_CNT_ZERO);
    end
  end

  // Open drain: the data value is always low, only the enable moves.
  assign pin_out = `DHA_PIN_LOW;
  assign busy = (cnt != `DHA_CNT_ZERO);

  a_pulse_len: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (start && !busy) |=> (!pin_oe_n) [*8])
    else $error("Acknowledge pulse ended too early.");

endmodule

// ### dha_handshake.sv
// Purpose: Acknowledge handshake sequencer of the single-wire debug halt interface.
// Assumes: Commands, bus status and CPU halted state come from logic on ref_clk;
//   the single_wire_debug_pin arrives asynchronously and is synchronised here.
// Notes: The pin is open drain; this block only ever pulls it low for the pulse.
//
// Notes on behaviour
// - With handshake on, pulse the pin once the CPU has carried out a command.
// - The enable command turns handshake on and is itself acknowledged.
// - Reset leaves the handshake off; no pulses until the host enables it.
// - Read commands acknowledge only after the bus cycle ends and data is ready.
// - Write commands acknowledge after all data arrived and the bus write ended.
// - Halt request acknowledges when the CPU enters the halted debug state.
// - Resume acknowledges when the CPU leaves the halted debug state.
// - Resume-until-halt resumes but acknowledges on the next halt entry.
// - Any halt entry raises that acknowledge, breakpoint or halt instruction alike.
// - Single step acknowledges when the CPU halts again after one instruction.
// - Resume with tagging never produces an acknowledge pulse.
// - The timing-probe command cancels a pending CPU-state acknowledge.
`timescale 1ns/1ps
`include "dha_consts.svh"

module dha_handshake (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Decoded commands from the serial decoder.
  input wire dha_pkg::dha_cmd_req_t cmd_in,
  output logic cmd_ready,
  // Internal bus access progress and CPU state.
  input wire dha_pkg::dha_bus_stat_t bus_st,
  input wire logic cpu_halted,
  // Open-drain single_wire_debug_pin.
  input wire logic pin_in,
  output logic pin_out,
  output logic pin_oe_n,
  // Status towards the rest of the debug halt interface.
  output logic ack_enabled,
  output logic ack_busy
);

  import dha_pkg::*;

  dha_state_t state;
  dha_state_t next_state;
  logic ack_en;
  logic next_ack_en;
  logic data_seen;
  logic next_data_seen;
  logic is_write;
  logic next_is_write;
  logic halted_q;
  logic line_high;
  logic pulse_start;
  logic pulse_busy;
  logic waiting_cpu;
  logic probe_hit;
  logic accept;
  logic halt_entry;
  logic halt_exit;

  // The pin level is only used to wait for a released line before pulling it low.
  dha_sync2 u_pin_sync (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .async_in(pin_in),
    .sync_out(line_high)
  );

  // Pulse generator owns the pin drive so the pulse length is fixed in one place.
  dha_pulse_gen u_pulse (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .start(pulse_start),
    .busy(pulse_busy),
    .pin_out(pin_out),
    .pin_oe_n(pin_oe_n)
  );

  // Edges of the CPU halted state; the CPU signal is on our clock, so no synchroniser.
  assign halt_entry = cpu_halted && !halted_q;
  assign halt_exit = !cpu_halted && halted_q;

  // While an acknowledge waits on the CPU only the timing probe is taken, which
  // keeps the host from stacking a second acknowledge behind a pending one.
  assign waiting_cpu = (state == DHA_S_WAIT_ENTER) || (state == DHA_S_WAIT_EXIT);
  assign probe_hit = cmd_in.valid && waiting_cpu && (cmd_in.code == DHA_CMD_TIMING_PROBE);
  assign cmd_ready = (state == DHA_S_IDLE) ||
                     (waiting_cpu && (cmd_in.code == DHA_CMD_TIMING_PROBE));
  assign accept = cmd_in.valid && (state == DHA_S_IDLE);
  assign pulse_start = (state == DHA_S_SEND) && line_high;

  // Next-state logic of the sequencer and its side flags.
  always_comb begin
    next_state = state;
    next_ack_en = ack_en;
    next_data_seen = data_seen;
    next_is_write = is_write;
    case (state)
      DHA_S_IDLE: begin
        next_data_seen = 1'h0;
        next_is_write = 1'h0;
        if (accept) begin
          case (cmd_in.code)
            DHA_CMD_ACK_ENABLE: begin
              next_ack_en = 1'h1;
              next_state = DHA_S_SEND;
            end
            DHA_CMD_ACK_DISABLE: begin
              next_ack_en = 1'h0;
            end
            DHA_CMD_READ: begin
              if (ack_en) begin
                next_state = DHA_S_WAIT_BUS;
              end
            end
            DHA_CMD_WRITE: begin
              if (ack_en) begin
                next_is_write = 1'h1;
                next_data_seen = bus_st.wr_data_done;
                next_state = DHA_S_WAIT_BUS;
              end
            end
            DHA_CMD_HALT_REQ, DHA_CMD_RESUME_UNTIL, DHA_CMD_SINGLE_STEP: begin
              if (ack_en) begin
                next_state = DHA_S_WAIT_ENTER;
              end
            end
            DHA_CMD_RESUME: begin
              if (ack_en) begin
                next_state = DHA_S_WAIT_EXIT;
              end
            end
            DHA_CMD_RESUME_TAG: begin
              next_state = DHA_S_IDLE;
            end
            default: begin
              next_state = DHA_S_IDLE;
            end
          endcase
        end
      end
      DHA_S_WAIT_BUS: begin
        // A write needs both its data over the pin and the bus cycle behind it.
        if (bus_st.wr_data_done) begin
          next_data_seen = 1'h1;
        end
        if (bus_st.bus_done && (!is_write || data_seen || bus_st.wr_data_done)) begin
          next_state = DHA_S_SEND;
        end
      end
      DHA_S_WAIT_ENTER: begin
        // Any halt entry counts, whatever caused it, for all three commands.
        if (probe_hit) begin
          next_state = DHA_S_IDLE;
        end else if (halt_entry) begin
          next_state = DHA_S_SEND;
        end
      end
      DHA_S_WAIT_EXIT: begin
        if (probe_hit) begin
          next_state = DHA_S_IDLE;
        end else if (halt_exit) begin
          next_state = DHA_S_SEND;
        end
      end
      DHA_S_SEND: begin
        // Hold off while something else still pulls the line low.
        if (line_high) begin
          next_state = DHA_S_PULSE;
        end
      end
      DHA_S_PULSE: begin
        if (!pulse_start && !pulse_busy) begin
          next_state = DHA_S_IDLE;
        end
      end
      default: begin
        next_state = DHA_S_IDLE;
      end
    endcase
  end

  // Register the sequencer; reset leaves the handshake off.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state <= DHA_S_IDLE;
      ack_en <= `DHA_ACK_EN_RST;
      data_seen <= 1'h0;
      is_write <= 1'h0;
      halted_q <= 1'h0;
    end else begin
      state <= next_state;
      ack_en <= next_ack_en;
      data_seen <= next_data_seen;
      is_write <= next_is_write;
      halted_q <= cpu_halted;
    end
  end

  // Status outputs: ack_enabled comes straight from its register, ack_busy is decoded from the state register.
  assign ack_enabled = ack_en;
  assign ack_busy = (state != DHA_S_IDLE);

  a_reset_off: assert property (@(posedge ref_clk)
    sys_rst |=> !ack_enabled)
    else $error("Handshake not off after reset.");

  a_enable_acked: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (accept && cmd_in.code == DHA_CMD_ACK_ENABLE) |=> ack_en ##[0:3] !pin_oe_n)
    else $error("Enable command not acknowledged.");

  a_off_silent: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (state == DHA_S_IDLE && !ack_en && !(accept && cmd_in.code == DHA_CMD_ACK_ENABLE))
    |=> state != DHA_S_SEND)
    else $error("Acknowledge started with handshake off.");

  a_read_waits: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (state == DHA_S_WAIT_BUS && !bus_st.bus_done) |=> state == DHA_S_WAIT_BUS)
    else $error("Acknowledge before bus cycle end.");

  a_write_waits: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (state == DHA_S_WAIT_BUS && is_write && !data_seen && !bus_st.wr_data_done)
    |=> state == DHA_S_WAIT_BUS)
    else $error("Write acknowledged before its data arrived.");

  a_entry_acked: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (state == DHA_S_WAIT_ENTER && halt_entry && !probe_hit) |=> state == DHA_S_SEND)
    else $error("Halt entry did not raise the acknowledge.");

  a_exit_acked: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (state == DHA_S_WAIT_EXIT && halt_exit && !probe_hit) |=> state == DHA_S_SEND)
    else $error("Halt exit did not raise the acknowledge.");

  a_tag_silent: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (accept && cmd_in.code == DHA_CMD_RESUME_TAG) |=> (state == DHA_S_IDLE && pin_oe_n))
    else $error("Tagging resume produced an acknowledge.");

  // A new command may follow right after the cancel, so only the next cycle is checked.
  a_probe_cancel: assert property (@(posedge ref_clk) disable iff (sys_rst)
    probe_hit |=> (state == DHA_S_IDLE && pin_oe_n))
    else $error("Timing probe did not cancel the acknowledge.");

  a_until_waits: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (accept && ack_en && cmd_in.code == DHA_CMD_RESUME_UNTIL)
    |=> (state == DHA_S_WAIT_ENTER && pin_oe_n))
    else $error("Resume-until-halt acknowledged before halt.");

  a_halt_wait: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (state == DHA_S_WAIT_ENTER && !halt_entry && !probe_hit) |=> state == DHA_S_WAIT_ENTER)
    else $error("Halt request acknowledged without halt entry.");

  // Reset and enable handling.
  a_reset_idle: assert property (@(posedge ref_clk)
    sys_rst |=> (state == DHA_S_IDLE && pin_oe_n))
    else $error("Sequencer not idle with pin released after reset.");

  a_enable_sets: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (accept && cmd_in.code == DHA_CMD_ACK_ENABLE) |=> (ack_en && state == DHA_S_SEND))
    else $error("Enable command did not turn the handshake on.");

  a_disable_quiet: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (accept && cmd_in.code == DHA_CMD_ACK_DISABLE) |=> (!ack_en && state == DHA_S_IDLE))
    else $error("Disable command did not turn the handshake off quietly.");

  a_off_no_wait: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (accept && !ack_en && cmd_in.code != DHA_CMD_ACK_ENABLE) |=> state == DHA_S_IDLE)
    else $error("Command waited for completion with handshake off.");

  // Idle and busy behaviour of the command port and the pin.
  a_idle_released: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (state == DHA_S_IDLE) |-> pin_oe_n)
    else $error("Pin pulled low while the sequencer is idle.");

  a_idle_ready: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (state == DHA_S_IDLE) |-> cmd_ready)
    else $error("Command port not ready while idle.");

  a_busy_refuse: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (state != DHA_S_IDLE && !waiting_cpu) |-> !cmd_ready)
    else $error("Command port ready during a bus wait or a pulse.");

  a_send_pulses: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (state == DHA_S_SEND && line_high) |=> (state == DHA_S_PULSE && !pin_oe_n))
    else $error("Released line did not start the acknowledge pulse.");

  // Completion of bus accesses and CPU state changes, and the enable kept over a tagging resume.
  a_read_acked: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (state == DHA_S_WAIT_BUS && !is_write && bus_st.bus_done) |=> state == DHA_S_SEND)
    else $error("Read bus end did not raise the acknowledge.");

  a_write_acked: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (state == DHA_S_WAIT_BUS && is_write && bus_st.bus_done &&
     (data_seen || bus_st.wr_data_done)) |=> state == DHA_S_SEND)
    else $error("Completed write did not raise the acknowledge.");

  a_exit_waits: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (state == DHA_S_WAIT_EXIT && !halt_exit && !probe_hit) |=> state == DHA_S_WAIT_EXIT)
    else $error("Resume acknowledged without halt exit.");

  a_tag_keeps_en: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (accept && cmd_in.code == DHA_CMD_RESUME_TAG) |=> (ack_en == $past(ack_en)))
    else $error("Tagging resume changed the handshake enable.");

endmodule

// ### dha_host_pod.sv
// Purpose: Behavioural model of the external debug pod on the single_wire_debug_pin.
// Assumes: The pin wire is resolved by the testbench with its pull-up.
// Notes: Only listens; each low stretch of the line counts as one acknowledge pulse.
`timescale 1ns/1ps

module dha_host_pod (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Resolved pin level.
  input wire logic pin,
  // What the pod has seen.
  output logic [7:0] pulse_cnt,
  output logic [7:0] last_len,
  output logic supported
);
  logic [7:0] low_len;

  // Measure low stretches; a completed one proves handshake support to the pod.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      low_len <= 8'h00;
      pulse_cnt <= 8'h00;
      last_len <= 8'h00;
      supported <= 1'b0;
    end else if (pin === 1'b0) begin
      low_len <= low_len + 8'h01;
    end else if (low_len != 8'h00) begin
      last_len <= low_len;
      pulse_cnt <= pulse_cnt + 8'h01;
      supported <= 1'b1;
      low_len <= 8'h00;
    end
  end
endmodule

// ### test_debug_handshake_ack.sv
// Purpose: Self-checking testbench of the debug handshake acknowledge block.
// Assumes: The pod only listens; the pin idles high through its pull-up.
// Notes: Each scenario drives one command, plus a timing probe in act 6, and counts the pulses the pod sees.
`timescale 1ns/1ps
`include "dha_consts.svh"

module test_debug_handshake_ack;
  import dha_pkg::*;

  // Long enough for any acknowledge; used where the pod may not wait for pulses.
  localparam int worst_wait = 40;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  dha_cmd_req_t cmd_in = '0;
  dha_bus_stat_t bus_st = '0;
  logic cpu_halted = 1'b0;
  logic cmd_ready, pin_out, pin_oe_n, ack_enabled, ack_busy, pin, supported;
  logic [7:0] pulse_cnt, last_len;
  integer seed = 85;
  int mismatches = 0;
  int checks = 0;

  // Open-drain line: released means high from the pull-up.
  assign pin = pin_oe_n ? 1'b1 : pin_out;

  always #5 ref_clk = ~ref_clk;

  dha_handshake dha_handshake_i (.ref_clk(ref_clk), .sys_rst(sys_rst), .cmd_in(cmd_in),
    .cmd_ready(cmd_ready), .bus_st(bus_st), .cpu_halted(cpu_halted), .pin_in(pin),
    .pin_out(pin_out), .pin_oe_n(pin_oe_n), .ack_enabled(ack_enabled), .ack_busy(ack_busy));

  dha_host_pod dha_host_pod_i (.ref_clk(ref_clk), .sys_rst(sys_rst), .pin(pin),
    .pulse_cnt(pulse_cnt), .last_len(last_len), .supported(supported));

  // Verdict; the only place the run ends.
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic check_bit(input string nm, input logic exp, input logic got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %b seen %b", nm, exp, got);
    end
  endtask

  task automatic check_val(input string nm, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %0d seen %0d", nm, exp, got);
    end
  endtask

  // Expected sequencer activity a few cycles after a command is taken.
  function automatic logic exp_busy(input dha_cmd_t c, input logic en);
    case (c)
      DHA_CMD_ACK_ENABLE: exp_busy = 1'h1;
      DHA_CMD_READ, DHA_CMD_WRITE, DHA_CMD_HALT_REQ, DHA_CMD_RESUME,
      DHA_CMD_RESUME_UNTIL, DHA_CMD_SINGLE_STEP: exp_busy = en;
      default: exp_busy = 1'h0;
    endcase
  endfunction

  // Reset is held five cycles, as after power-up.
  task automatic do_reset();
    sys_rst <= 1'b1;
    repeat (5) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
  endtask

  // One command, valid for exactly one cycle; caller sits just after an edge.
  task automatic send(input dha_cmd_t c);
    cmd_in <= '{valid: 1'b1, code: c};
    @(posedge ref_clk);
    cmd_in <= '0;
  endtask

  task automatic bus_pulse(input dha_bus_stat_t v);
    bus_st <= v;
    @(posedge ref_clk);
    bus_st <= '0;
  endtask

  // Bounded wait for the sequencer to go idle; a hang ends the run as a failure.
  task automatic wait_idle();
    int i;
    repeat (2) @(posedge ref_clk);
    for (i = 0; i < 200 && ack_busy !== 1'b0; i++) @(posedge ref_clk);
    if (i == 200) begin
      mismatches++;
      $display("wrong value ack_busy expected 0 seen stuck");
      final_report();
    end
    repeat (3) @(posedge ref_clk);
  endtask

  // Acts: 1 bus end, 2 write data then bus end, 3 halt entry, 4 halt exit,
  // 5 exit then later entry, 6 timing probe then the awaited CPU change.
  task automatic run(input string nm, input dha_cmd_t c, input logic h0, input int act,
                     input int exp);
    logic [7:0] base;
    int gap;
    logic en;
    @(posedge ref_clk);
    cpu_halted <= h0;
    repeat (3) @(posedge ref_clk);
    base = pulse_cnt;
    en = ack_enabled;
    gap = 2 + ($unsigned($random(seed)) % 8);
    send(c);
    repeat (gap) @(posedge ref_clk);
    check_val("pulses before completion", base, pulse_cnt);
    check_bit("ack_busy", exp_busy(c, en), ack_busy);
    check_bit("cmd_ready", !exp_busy(c, en), cmd_ready);
    case (act)
      // A stray random write-data flag must not disturb a read.
      1: bus_pulse({1'h1, gap[0]});
      2: begin
        bus_pulse(2'b01);
        repeat (gap) @(posedge ref_clk);
        check_val("pulses before bus end", base, pulse_cnt);
        bus_pulse(2'b10);
      end
      3: cpu_halted <= 1'b1;
      4: cpu_halted <= 1'b0;
      5: begin
        cpu_halted <= 1'b0;
        repeat (gap) @(posedge ref_clk);
        check_val("pulses before halt entry", base, pulse_cnt);
        cpu_halted <= 1'b1;
      end
      6: begin
        send(DHA_CMD_TIMING_PROBE);
        check_bit("cmd_ready", 1'b1, cmd_ready);
        cpu_halted <= ~h0;
      end
      default: ;
    endcase
    // Without handshake the pod sits out the worst-case delay instead.
    if (ack_enabled !== 1'b1) repeat (worst_wait) @(posedge ref_clk);
    wait_idle();
    check_val("ack pulses", base + 8'(exp), pulse_cnt);
    if (exp != 0) check_val("pulse length", 8'(`DHA_ACK_PULSE_CYC), last_len);
    $display("test %s done", nm);
  endtask

  // Main sequence; random gaps vary the distance between command and completion.
  initial begin
    do_reset();
    check_bit("ack_enabled", 1'b0, ack_enabled);
    check_bit("pin_oe_n", 1'b1, pin_oe_n);
    check_bit("pin_out", 1'b0, pin_out);
    check_bit("cmd_ready", 1'b1, cmd_ready);
    run("read while off", DHA_CMD_READ, 1'b0, 1, 0);
    run("enable", DHA_CMD_ACK_ENABLE, 1'b0, 0, 1);
    check_bit("ack_enabled", 1'b1, ack_enabled);
    check_bit("supported", 1'b1, supported);
    repeat (4) run("read", DHA_CMD_READ, 1'b0, 1, 1);
    repeat (3) run("write", DHA_CMD_WRITE, 1'b0, 2, 1);
    run("halt request", DHA_CMD_HALT_REQ, 1'b0, 3, 1);
    run("resume", DHA_CMD_RESUME, 1'b1, 4, 1);
    repeat (2) run("resume until", DHA_CMD_RESUME_UNTIL, 1'b1, 5, 1);
    run("single step", DHA_CMD_SINGLE_STEP, 1'b1, 5, 1);
    run("resume tagging", DHA_CMD_RESUME_TAG, 1'b1, 5, 0);
    run("halt probe", DHA_CMD_HALT_REQ, 1'b0, 6, 0);
    run("resume probe", DHA_CMD_RESUME, 1'b1, 6, 0);
    run("disable", DHA_CMD_ACK_DISABLE, 1'b0, 0, 0);
    check_bit("ack_enabled", 1'b0, ack_enabled);
    run("read after disable", DHA_CMD_READ, 1'b0, 1, 0);
    run("halt after disable", DHA_CMD_HALT_REQ, 1'b0, 3, 0);
    run("enable again", DHA_CMD_ACK_ENABLE, 1'b0, 0, 1);
    do_reset();
    check_bit("ack_enabled", 1'b0, ack_enabled);
    run("read after reset", DHA_CMD_READ, 1'b0, 1, 0);
    final_report();
  end
endmodule
